/* File: rtl/icx_map.vh */
`ifndef ICX_MAP_VH
`define ICX_MAP_VH

// Execution opcodes presented by the program sequencer.
`define ICX_OP_W          5
`define ICX_OP_IDLE       5'h00
`define ICX_OP_PWR_DOWN   5'h01
`define ICX_OP_INC_MEM    5'h02
`define ICX_OP_INC_WORK   5'h03
`define ICX_OP_BRANCH     5'h04
`define ICX_OP_LD_MEM     5'h05
`define ICX_OP_LD_IMM     5'h06
`define ICX_OP_ST_MEM     5'h07
`define ICX_OP_OR_MEM     5'h08
`define ICX_OP_OR_IMM     5'h09
`define ICX_OP_OR_TO_MEM  5'h0A
`define ICX_OP_SUB_EXIT   5'h0B
`define ICX_OP_EXIT_IMM   5'h0C
`define ICX_OP_IRQ_EXIT   5'h0D
`define ICX_OP_ROL_MEM    5'h0E
`define ICX_OP_ROL_WORK   5'h0F
`define ICX_OP_ROLC_MEM   5'h10
`define ICX_OP_ROLC_WORK  5'h11
`define ICX_OP_ROR_MEM    5'h12
`define ICX_OP_ROR_WORK   5'h13
`define ICX_OP_RORC_MEM   5'h14
`define ICX_OP_RORC_WORK  5'h15
`define ICX_OP_CALL       5'h16

// Register byte offsets on the bus.
`define ICX_ADDR_W        8
`define ICX_OFS_CTRL      8'h00
`define ICX_OFS_STATUS    8'h04
`define ICX_OFS_WORK      8'h08
`define ICX_OFS_PC        8'h0C
`define ICX_OFS_WDOG      8'h10

// Control register fields.
`define ICX_CTRL_RUN      0
`define ICX_CTRL_WAKE     1
`define ICX_CTRL_RST      1'h1

// Status register fields.
`define ICX_ST_CARRY      0
`define ICX_ST_ZERO       1
`define ICX_ST_PD         2
`define ICX_ST_EXPIRY     3
`define ICX_ST_GIE        4
`define ICX_ST_HALTED     5

// Interrupt control register: global enable position.
`define ICX_IRQC_GIE      0

// Core states.
`define ICX_ST_W          2
`define ICX_S_RUN         2'h0
`define ICX_S_SECOND      2'h1
`define ICX_S_HALT        2'h2

// Watchdog prescaler width and bus responses.
`define ICX_PRE_W         8
`define ICX_RESP_OKAY     2'h0
`define ICX_RESP_SLVERR   2'h2

`endif

/* File: rtl/icx_core.v */
`timescale 1ns/1ps
// What this block does
// - Power-down stops execution, gates clock, keeps state.
// - Power-down clears watchdog, sets pd, clears expiry.
// - Memory increment writes byte plus one, zero only.
// - Increment-to-working loads byte plus one, zero only.
// - Direct branch loads target address, no flags.
// - Load from memory into working, no flags.
// - Load immediate constant into working, no flags.
// - Store working into memory, no flags.
// - Idle only advances the program counter.
// - OR memory into working, zero only.
// - OR immediate into working, zero only.
// - OR working into memory byte, zero only.
// - Subroutine exit pops PC, two cycles, no flags.
// - Exit with constant pops PC, loads working.
// - Interrupt exit pops PC, sets global enable.
// - Rotate left into memory, carry untouched.
// - Rotate left into working, memory unchanged.
// - Rotate left through carry into memory.
// - Rotate left through carry into working, carry updated.
// - Rotate right into memory, no flags.
// - Rotate right into working, memory untouched.
// - Rotate right through carry into memory.
// - Call pushes next address onto return stack.
`include "icx_map.vh"

module icx_core #(
    parameter PC_W     = 12,
    parameter DADDR_W  = 8,
    parameter STK_D    = 8,
    parameter STK_W    = 3
) (
    input  wire                   mclk_i,
    input  wire                   rstn_i,
    input  wire                   instr_valid_i,
    input  wire [`ICX_OP_W-1:0]   instr_op_i,
    input  wire [DADDR_W-1:0]     instr_addr_i,
    input  wire [7:0]             instr_imm_i,
    input  wire [PC_W-1:0]        instr_target_i,
    input  wire                   wake_i,
    output wire                   instr_ready_o,
    output wire                   flush_o,
    output wire                   clk_run_o,
    output wire [PC_W-1:0]        pc_o,
    output wire [7:0]             work_o,
    output wire                   carry_o,
    output wire                   zero_o,
    output wire                   global_irq_enable_o,
    input  wire [`ICX_ADDR_W-1:0] s_awaddr_i,
    input  wire                   s_awvalid_i,
    output wire                   s_awready_o,
    input  wire [31:0]            s_wdata_i,
    input  wire [3:0]             s_wstrb_i,
    input  wire                   s_wvalid_i,
    output wire                   s_wready_o,
    output wire [1:0]             s_bresp_o,
    output wire                   s_bvalid_o,
    input  wire                   s_bready_i,
    input  wire [`ICX_ADDR_W-1:0] s_araddr_i,
    input  wire                   s_arvalid_i,
    output wire                   s_arready_o,
    output wire [31:0]            s_rdata_o,
    output wire [1:0]             s_rresp_o,
    output wire                   s_rvalid_o,
    input  wire                   s_rready_i
);

    reg [7:0]             dmem [0:(1<<DADDR_W)-1];
    reg [PC_W-1:0]        stack [0:STK_D-1];
    reg [STK_W-1:0]       sp_r;
    reg [`ICX_ST_W-1:0]   state_r;
    reg [`ICX_ST_W-1:0]   state_nxt;
    reg                   ready_r;
    reg                   flush_r;
    reg [PC_W-1:0]        pc_r;
    reg [7:0]             work_r;
    reg                   carry_r;
    reg                   zero_r;
    reg                   pd_r;
    reg                   expiry_r;
    reg                   gie_r;
    reg                   run_en_r;
    reg                   clk_run_r;
    reg [`ICX_PRE_W-1:0]  wd_pre_r;
    reg [7:0]             wd_cnt_r;

    reg [PC_W-1:0]        pc_nxt;
    reg [7:0]             work_nxt;
    reg                   work_we;
    reg [7:0]             mem_wd;
    reg                   mem_we;
    reg                   carry_nxt;
    reg                   carry_we;
    reg                   zero_we;
    reg [7:0]             zero_src;
    reg                   push;
    reg                   pop;
    reg                   gie_set;
    reg                   halt_go;
    reg                   two_cyc;

    reg                   awready_r;
    reg                   wready_r;
    reg                   bvalid_r;
    reg [1:0]             bresp_r;
    reg [`ICX_ADDR_W-1:0] awaddr_r;
    reg [31:0]            wdata_r;
    reg [3:0]             wstrb_r;
    reg                   arready_r;
    reg                   rvalid_r;
    reg [1:0]             rresp_r;
    reg [31:0]            rdata_r;

    wire [7:0]            mem_rd   = dmem[instr_addr_i];
    wire                  fire     = instr_valid_i & ready_r & (state_r == `ICX_S_RUN);
    wire [STK_W-1:0]      sp_dec   = sp_r - {{(STK_W-1){1'b0}}, 1'b1};
    wire [PC_W-1:0]       pc_inc   = pc_r + {{(PC_W-1){1'b0}}, 1'b1};
    wire                  wr_go    = ~awready_r & ~wready_r & ~bvalid_r;
    wire [2:0]            wr_sel   = icx_sel(awaddr_r);
    wire                  wr_lo    = wr_go & wstrb_r[0];
    wire                  ctrl_wr  = wr_lo & (wr_sel == 3'h0);
    wire                  stat_wr  = wr_lo & (wr_sel == 3'h1);
    wire                  work_wr  = wr_lo & (wr_sel == 3'h2);
    wire                  wake_req = wake_i | (ctrl_wr & wdata_r[`ICX_CTRL_WAKE]);
    wire                  wd_tick  = &wd_pre_r;

    // Register index from byte address; 3'h7 marks an unmapped address.
    function [2:0] icx_sel;
        input [`ICX_ADDR_W-1:0] a;
        begin
            case (a)
                `ICX_OFS_CTRL:   icx_sel = 3'h0;
                `ICX_OFS_STATUS: icx_sel = 3'h1;
                `ICX_OFS_WORK:   icx_sel = 3'h2;
                `ICX_OFS_PC:     icx_sel = 3'h3;
                `ICX_OFS_WDOG:   icx_sel = 3'h4;
                default:         icx_sel = 3'h7;
            endcase
        end
    endfunction

    // Nine-bit ring rotation of {carry, byte}; dir 1 is left.
    function [8:0] icx_rotc;
        input [7:0] b;
        input       c;
        input       dir;
        begin
            icx_rotc = dir ? {b[7], b[6:0], c} : {b[0], c, b[7:1]};
        end
    endfunction

    always @* begin
        pc_nxt    = pc_inc;
        work_nxt  = work_r;
        work_we   = 1'b0;
        mem_wd    = mem_rd;
        mem_we    = 1'b0;
        carry_nxt = carry_r;
        carry_we  = 1'b0;
        zero_we   = 1'b0;
        zero_src  = 8'h00;
        push      = 1'b0;
        pop       = 1'b0;
        gie_set   = 1'b0;
        halt_go   = 1'b0;
        two_cyc   = 1'b0;
        case (instr_op_i)
            `ICX_OP_IDLE:     pc_nxt = pc_inc;
            `ICX_OP_PWR_DOWN: halt_go = 1'b1;
            `ICX_OP_INC_MEM: begin
                mem_wd   = mem_rd + 8'h01;
                mem_we   = 1'b1;
                zero_we  = 1'b1;
                zero_src = mem_wd;
            end
            `ICX_OP_INC_WORK: begin
                work_nxt = mem_rd + 8'h01;
                work_we  = 1'b1;
                zero_we  = 1'b1;
                zero_src = work_nxt;
            end
            `ICX_OP_BRANCH: pc_nxt = instr_target_i;
            `ICX_OP_CALL: begin
                pc_nxt = instr_target_i;
                push   = 1'b1;
            end
            `ICX_OP_LD_MEM: begin
                work_nxt = mem_rd;
                work_we  = 1'b1;
            end
            `ICX_OP_LD_IMM: begin
                work_nxt = instr_imm_i;
                work_we  = 1'b1;
            end
            `ICX_OP_ST_MEM: begin
                mem_wd = work_r;
                mem_we = 1'b1;
            end
            `ICX_OP_OR_MEM: begin
                work_nxt = work_r | mem_rd;
                work_we  = 1'b1;
                zero_we  = 1'b1;
                zero_src = work_nxt;
            end
            `ICX_OP_OR_IMM: begin
                work_nxt = work_r | instr_imm_i;
                work_we  = 1'b1;
                zero_we  = 1'b1;
                zero_src = work_nxt;
            end
            `ICX_OP_OR_TO_MEM: begin
                mem_wd   = work_r | mem_rd;
                mem_we   = 1'b1;
                zero_we  = 1'b1;
                zero_src = mem_wd;
            end
            `ICX_OP_SUB_EXIT: begin
                pc_nxt  = stack[sp_dec];
                pop     = 1'b1;
                two_cyc = 1'b1;
            end
            `ICX_OP_EXIT_IMM: begin
                pc_nxt   = stack[sp_dec];
                pop      = 1'b1;
                work_nxt = instr_imm_i;
                work_we  = 1'b1;
                two_cyc  = 1'b1;
            end
            `ICX_OP_IRQ_EXIT: begin
                pc_nxt  = stack[sp_dec];
                pop     = 1'b1;
                gie_set = 1'b1;
                two_cyc = 1'b1;
            end
            `ICX_OP_ROL_MEM: begin
                mem_wd = {mem_rd[6:0], mem_rd[7]};
                mem_we = 1'b1;
            end
            `ICX_OP_ROL_WORK: begin
                work_nxt = {mem_rd[6:0], mem_rd[7]};
                work_we  = 1'b1;
            end
            `ICX_OP_ROLC_MEM: begin
                {carry_nxt, mem_wd} = icx_rotc(mem_rd, carry_r, 1'b1);
                mem_we   = 1'b1;
                carry_we = 1'b1;
            end
            `ICX_OP_ROLC_WORK: begin
                {carry_nxt, work_nxt} = icx_rotc(mem_rd, carry_r, 1'b1);
                work_we  = 1'b1;
                carry_we = 1'b1;
            end
            `ICX_OP_ROR_MEM: begin
                mem_wd = {mem_rd[0], mem_rd[7:1]};
                mem_we = 1'b1;
            end
            `ICX_OP_ROR_WORK: begin
                work_nxt = {mem_rd[0], mem_rd[7:1]};
                work_we  = 1'b1;
            end
            `ICX_OP_RORC_MEM: begin
                {carry_nxt, mem_wd} = icx_rotc(mem_rd, carry_r, 1'b0);
                mem_we   = 1'b1;
                carry_we = 1'b1;
            end
            `ICX_OP_RORC_WORK: begin
                {carry_nxt, work_nxt} = icx_rotc(mem_rd, carry_r, 1'b0);
                work_we  = 1'b1;
                carry_we = 1'b1;
            end
            default: pc_nxt = pc_inc;
        endcase
    end

    always @* begin
        state_nxt = state_r;
        case (state_r)
            `ICX_S_RUN: begin
                if (fire && halt_go) begin
                    state_nxt = `ICX_S_HALT;
                end else if (fire && two_cyc) begin
                    state_nxt = `ICX_S_SECOND;
                end
            end
            `ICX_S_SECOND: begin
                state_nxt = `ICX_S_RUN;
            end
            `ICX_S_HALT: begin
                if (wake_req) begin
                    state_nxt = `ICX_S_RUN;
                end
            end
            default: begin
                state_nxt = `ICX_S_RUN;
            end
        endcase
    end

    // Memories carry no reset so that a power-down never disturbs them.
    always @(posedge mclk_i) begin
        if (fire && mem_we) begin
            dmem[instr_addr_i] <= mem_wd;
        end
        if (fire && push) begin
            stack[sp_r] <= pc_inc;
        end
    end

    always @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state_r  <= `ICX_S_RUN;
            ready_r  <= 1'b0;
            flush_r  <= 1'b0;
            pc_r     <= {PC_W{1'b0}};
            sp_r     <= {STK_W{1'b0}};
            work_r   <= 8'h00;
            carry_r  <= 1'b0;
            zero_r   <= 1'b0;
            pd_r     <= 1'b0;
            expiry_r <= 1'b0;
            gie_r    <= 1'b0;
            run_en_r <= `ICX_CTRL_RST;
            clk_run_r <= 1'b1;
            wd_pre_r <= {`ICX_PRE_W{1'b0}};
            wd_cnt_r <= 8'h00;
        end else begin
            state_r   <= state_nxt;
            clk_run_r <= (state_nxt != `ICX_S_HALT);
            ready_r <= (state_nxt == `ICX_S_RUN) & (ctrl_wr ? wdata_r[`ICX_CTRL_RUN] : run_en_r);
            flush_r <= fire & two_cyc;
            if (ctrl_wr) begin
                run_en_r <= wdata_r[`ICX_CTRL_RUN];
            end
            if (stat_wr) begin
                carry_r <= wdata_r[`ICX_ST_CARRY];
                zero_r  <= wdata_r[`ICX_ST_ZERO];
                gie_r   <= wdata_r[`ICX_ST_GIE];
            end
            if (work_wr) begin
                work_r <= wdata_r[7:0];
            end
            wd_pre_r <= wd_pre_r + {{(`ICX_PRE_W-1){1'b0}}, 1'b1};
            if (wd_tick) begin
                wd_cnt_r <= wd_cnt_r + 8'h01;
                if (&wd_cnt_r) begin
                    expiry_r <= 1'b1;
                end
            end
            if (fire) begin
                pc_r <= pc_nxt;
                if (work_we) begin
                    work_r <= work_nxt;
                end
                if (carry_we) begin
                    carry_r <= carry_nxt;
                end
                if (zero_we) begin
                    zero_r <= (zero_src == 8'h00);
                end
                if (push) begin
                    sp_r <= sp_r + {{(STK_W-1){1'b0}}, 1'b1};
                end
                if (pop) begin
                    sp_r <= sp_dec;
                end
                // Enable and PC change on one edge, and the next fetch is held off.
                if (gie_set) begin
                    gie_r <= 1'b1;
                end
                if (halt_go) begin
                    wd_pre_r <= {`ICX_PRE_W{1'b0}};
                    wd_cnt_r <= 8'h00;
                    pd_r     <= 1'b1;
                    expiry_r <= 1'b0;
                end
            end
        end
    end

    always @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            awready_r <= 1'b1;
            wready_r  <= 1'b1;
            bvalid_r  <= 1'b0;
            bresp_r   <= `ICX_RESP_OKAY;
            awaddr_r  <= {`ICX_ADDR_W{1'b0}};
            wdata_r   <= 32'h00000000;
            wstrb_r   <= 4'h0;
            arready_r <= 1'b1;
            rvalid_r  <= 1'b0;
            rresp_r   <= `ICX_RESP_OKAY;
            rdata_r   <= 32'h00000000;
        end else begin
            if (s_awvalid_i && awready_r) begin
                awaddr_r  <= s_awaddr_i;
                awready_r <= 1'b0;
            end
            if (s_wvalid_i && wready_r) begin
                wdata_r  <= s_wdata_i;
                wstrb_r  <= s_wstrb_i;
                wready_r <= 1'b0;
            end
            if (wr_go) begin
                bvalid_r <= 1'b1;
                bresp_r  <= (wr_sel == 3'h7) ? `ICX_RESP_SLVERR : `ICX_RESP_OKAY;
            end
            if (bvalid_r && s_bready_i) begin
                bvalid_r  <= 1'b0;
                awready_r <= 1'b1;
                wready_r  <= 1'b1;
            end
            if (s_arvalid_i && arready_r) begin
                arready_r <= 1'b0;
                rvalid_r  <= 1'b1;
                rresp_r   <= `ICX_RESP_OKAY;
                case (icx_sel(s_araddr_i))
                    3'h0: rdata_r <= {31'h00000000, run_en_r};
                    3'h1: rdata_r <= {26'h0000000, state_r == `ICX_S_HALT, gie_r, expiry_r, pd_r, zero_r, carry_r};
                    3'h2: rdata_r <= {24'h000000, work_r};
                    3'h3: rdata_r <= {{(32-PC_W){1'b0}}, pc_r};
                    3'h4: rdata_r <= {24'h000000, wd_cnt_r};
                    default: begin
                        rdata_r <= 32'h00000000;
                        rresp_r <= `ICX_RESP_SLVERR;
                    end
                endcase
            end
            if (rvalid_r && s_rready_i) begin
                rvalid_r  <= 1'b0;
                arready_r <= 1'b1;
            end
        end
    end

    assign instr_ready_o       = ready_r;
    assign flush_o             = flush_r;
    assign clk_run_o           = clk_run_r;
    assign pc_o                = pc_r;
    assign work_o              = work_r;
    assign carry_o             = carry_r;
    assign zero_o              = zero_r;
    assign global_irq_enable_o = gie_r;
    assign s_awready_o         = awready_r;
    assign s_wready_o          = wready_r;
    assign s_bvalid_o          = bvalid_r;
    assign s_bresp_o           = bresp_r;
    assign s_arready_o         = arready_r;
    assign s_rvalid_o          = rvalid_r;
    assign s_rresp_o           = rresp_r;
    assign s_rdata_o           = rdata_r;

endmodule // icx_core

/* File: sim/icx_core_monitor.sv */
`timescale 1ns/1ps
`include "icx_map.vh"
module icx_core_monitor #(
    parameter PC_W = 12
) (
    input wire                 mclk_i,
    input wire                 rstn_i,
    input wire                 instr_valid_i,
    input wire [`ICX_OP_W-1:0] instr_op_i,
    input wire [7:0]           instr_imm_i,
    input wire [PC_W-1:0]      instr_target_i,
    input wire                 wake_i,
    input wire                 instr_ready_o,
    input wire                 flush_o,
    input wire                 clk_run_o,
    input wire [PC_W-1:0]      pc_o,
    input wire [7:0]           work_o,
    input wire                 carry_o,
    input wire                 zero_o,
    input wire                 global_irq_enable_o
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rstn_i);
    wire tk  = instr_valid_i && instr_ready_o;
    wire ret = instr_op_i inside {`ICX_OP_SUB_EXIT, `ICX_OP_EXIT_IMM, `ICX_OP_IRQ_EXIT};
    wire rot = instr_op_i inside {`ICX_OP_ROL_MEM, `ICX_OP_ROL_WORK, `ICX_OP_ROR_MEM, `ICX_OP_ROR_WORK};
    property p_ret_gap; tk && ret |=> !instr_ready_o && flush_o ##1 instr_ready_o && !flush_o; endproperty
    a_ret_gap: assert property (p_ret_gap) else $error("return gap wrong");
    property p_single; tk && !ret && instr_op_i != `ICX_OP_PWR_DOWN |=> instr_ready_o; endproperty
    a_single: assert property (p_single) else $error("one-cycle op stalled");
    property p_halt; tk && instr_op_i == `ICX_OP_PWR_DOWN |=> !clk_run_o && !instr_ready_o
        && pc_o == $past(pc_o) + 1'b1; endproperty
    a_halt: assert property (p_halt) else $error("power-down entry wrong");
    property p_hold; !clk_run_o && !wake_i |=> $stable(pc_o) && $stable(work_o) && !instr_ready_o; endproperty
    a_hold: assert property (p_hold) else $error("state moved while halted");
    property p_wake; !clk_run_o && wake_i |=> clk_run_o && instr_ready_o; endproperty
    a_wake: assert property (p_wake) else $error("wake not taken");
    property p_branch; tk && instr_op_i == `ICX_OP_BRANCH |=> pc_o == $past(instr_target_i)
        && $stable({carry_o, zero_o}); endproperty
    a_branch: assert property (p_branch) else $error("branch wrong");
    property p_ld_imm; tk && instr_op_i == `ICX_OP_LD_IMM |=> work_o == $past(instr_imm_i)
        && $stable({carry_o, zero_o}); endproperty
    a_ld_imm: assert property (p_ld_imm) else $error("immediate load wrong");
    property p_or_imm; tk && instr_op_i == `ICX_OP_OR_IMM |=> work_o == ($past(work_o) | $past(instr_imm_i))
        && zero_o == (work_o == 8'h00) && $stable(carry_o); endproperty
    a_or_imm: assert property (p_or_imm) else $error("immediate or wrong");
    property p_irq_exit; tk && instr_op_i == `ICX_OP_IRQ_EXIT |=> global_irq_enable_o && !instr_ready_o; endproperty
    a_irq_exit: assert property (p_irq_exit) else $error("irq exit wrong");
    property p_rot_flags; tk && rot |=> $stable(carry_o) && $stable(zero_o); endproperty
    a_rot_flags: assert property (p_rot_flags) else $error("rotate touched flags");
    c_ret: cover property (tk && ret);
    c_halt: cover property (tk && instr_op_i == `ICX_OP_PWR_DOWN);
    c_wake: cover property (!clk_run_o && wake_i);
endmodule // icx_core_monitor

bind icx_core icx_core_monitor #(.PC_W(PC_W)) i_icx_core_monitor (.*);

/* File: sim/icx_core_test.sv */
`timescale 1ns/1ps
`include "icx_map.vh"
module icx_core_test;
    reg         clk = 1'b0, rstn = 1'b0, iv = 1'b0, wake = 1'b0;
    reg         awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0;
    reg  [4:0]  iop = 5'h00;
    reg  [7:0]  ia = 8'h00, iim = 8'h00, awa = 8'h00, ara = 8'h00;
    reg  [11:0] itg = 12'h000;
    reg  [31:0] wd = 32'h00000000;
    wire        rdy, fl, run, awr, wr, bv, arr, rv, cy, zf, gie;
    wire [11:0] pc;
    wire [7:0]  wk;
    wire [1:0]  bresp, rresp;
    wire [31:0] rdat;
    integer     err_count = 0;
    integer     checked   = 0;
    integer     seed      = 54;
    integer     i;
    reg  [7:0]  mem [0:255];
    reg  [7:0]  m_wk = 8'h00, r;
    reg  [11:0] m_pc = 12'h000;
    reg         m_c = 1'b0, m_z = 1'b0, m_g = 1'b0;
    reg  [11:0] stk [$];
    reg  [31:0] d;
    reg  [1:0]  rs;
    reg  [4:0]  op;

    icx_core i_icx_core (
        .mclk_i(clk), .rstn_i(rstn), .instr_valid_i(iv), .instr_op_i(iop), .instr_addr_i(ia),
        .instr_imm_i(iim), .instr_target_i(itg), .wake_i(wake), .instr_ready_o(rdy), .flush_o(fl),
        .clk_run_o(run), .pc_o(pc), .work_o(wk), .carry_o(cy), .zero_o(zf), .global_irq_enable_o(gie),
        .s_awaddr_i(awa), .s_awvalid_i(awv), .s_awready_o(awr), .s_wdata_i(wd), .s_wstrb_i(4'hF),
        .s_wvalid_i(wv), .s_wready_o(wr), .s_bresp_o(bresp), .s_bvalid_o(bv), .s_bready_i(br),
        .s_araddr_i(ara), .s_arvalid_i(arv), .s_arready_o(arr), .s_rdata_o(rdat), .s_rresp_o(rresp),
        .s_rvalid_o(rv), .s_rready_i(rr));

    initial begin
        forever #2 clk = ~clk;
    end

    task finish_test;
        begin
            if (err_count == 0 && checked > 0)
                $display("Simulation passed");
            else
                $display("Simulation failed");
            $finish;
        end
    endtask

    task chk_val(input [33:0] got, input [33:0] exp);
        begin
            checked = checked + 1;
            if (got !== exp) begin
                err_count = err_count + 1;
                $display("[ERR] %0t got %h exp %h", $time, got, exp);
            end
        end
    endtask

    task chk_core;
        begin
            chk_val({pc, wk, cy, zf, gie}, {m_pc, m_wk, m_c, m_z, m_g});
        end
    endtask

    task model(input [4:0] o, input [7:0] a, input [7:0] im, input [11:0] t);
        reg [7:0] v;
        begin
            v = mem[a];
            case (o)
                `ICX_OP_INC_MEM, `ICX_OP_INC_WORK: r = v + 8'h01;
                `ICX_OP_LD_MEM: r = v;
                `ICX_OP_LD_IMM, `ICX_OP_EXIT_IMM: r = im;
                `ICX_OP_ST_MEM: r = m_wk;
                `ICX_OP_OR_MEM, `ICX_OP_OR_TO_MEM: r = v | m_wk;
                `ICX_OP_OR_IMM: r = im | m_wk;
                `ICX_OP_ROL_MEM, `ICX_OP_ROL_WORK: r = {v[6:0], v[7]};
                `ICX_OP_ROLC_MEM, `ICX_OP_ROLC_WORK: r = {v[6:0], m_c};
                `ICX_OP_ROR_MEM, `ICX_OP_ROR_WORK: r = {v[0], v[7:1]};
                `ICX_OP_RORC_MEM, `ICX_OP_RORC_WORK: r = {m_c, v[7:1]};
                default: r = m_wk;
            endcase
            if (o inside {`ICX_OP_INC_MEM, `ICX_OP_ST_MEM, `ICX_OP_OR_TO_MEM, `ICX_OP_ROL_MEM,
                          `ICX_OP_ROLC_MEM, `ICX_OP_ROR_MEM, `ICX_OP_RORC_MEM})
                mem[a] = r;
            else
                m_wk = r;
            if (o inside {`ICX_OP_INC_MEM, `ICX_OP_INC_WORK, `ICX_OP_OR_MEM, `ICX_OP_OR_IMM, `ICX_OP_OR_TO_MEM})
                m_z = (r == 8'h00);
            if (o inside {`ICX_OP_ROLC_MEM, `ICX_OP_ROLC_WORK})
                m_c = v[7];
            if (o inside {`ICX_OP_RORC_MEM, `ICX_OP_RORC_WORK})
                m_c = v[0];
            m_pc = m_pc + 12'h001;
            if (o == `ICX_OP_CALL)
                stk.push_back(m_pc);
            if (o inside {`ICX_OP_BRANCH, `ICX_OP_CALL})
                m_pc = t;
            if (o inside {`ICX_OP_SUB_EXIT, `ICX_OP_EXIT_IMM, `ICX_OP_IRQ_EXIT})
                m_pc = stk.pop_back();
            if (o == `ICX_OP_IRQ_EXIT)
                m_g = 1'b1;
        end
    endtask

    task exec(input [4:0] o, input [7:0] a, input [7:0] im, input [11:0] t);
        begin
            @(posedge clk);
            iop <= o;
            ia  <= a;
            iim <= im;
            itg <= t;
            iv  <= 1'b1;
            @(posedge clk);
            while (rdy !== 1'b1)
                @(posedge clk);
            iv <= 1'b0;
            model(o, a, im, t);
            #1 chk_core;
        end
    endtask

    task axi_wr(input [7:0] a, input [31:0] dt, output [1:0] resp);
        begin
            @(posedge clk);
            awa <= a;
            wd  <= dt;
            awv <= 1'b1;
            wv  <= 1'b1;
            br  <= 1'b1;
            do begin
                @(posedge clk);
                if (awr)
                    awv <= 1'b0;
                if (wr)
                    wv <= 1'b0;
            end while (bv !== 1'b1);
            resp = bresp;
            br <= 1'b0;
        end
    endtask

    task axi_rd(input [7:0] a, output [31:0] dt, output [1:0] resp);
        begin
            @(posedge clk);
            ara <= a;
            arv <= 1'b1;
            rr  <= 1'b1;
            do begin
                @(posedge clk);
                if (arr)
                    arv <= 1'b0;
            end while (rv !== 1'b1);
            dt = rdat;
            resp = rresp;
            rr <= 1'b0;
        end
    endtask

    initial begin
        #200000;
        err_count = err_count + 1;
        finish_test;
    end

    initial begin
        repeat (6) @(posedge clk);
        rstn <= 1'b1;
        axi_rd(`ICX_OFS_CTRL, d, rs);
        chk_val({rs, d}, {`ICX_RESP_OKAY, 32'h00000001});
        axi_rd(8'h40, d, rs);
        chk_val({rs, d}, {`ICX_RESP_SLVERR, 32'h00000000});
        axi_wr(8'h40, 32'h000000FF, rs);
        chk_val(rs, `ICX_RESP_SLVERR);
        axi_wr(`ICX_OFS_WORK, 32'h0000005A, rs);
        m_wk = 8'h5A;
        chk_val(rs, `ICX_RESP_OKAY);
        // Data memory has no reset, so seed the bytes the random run touches.
        for (i = 0; i < 8; i = i + 1) begin
            exec(`ICX_OP_LD_IMM, 8'h00, $random(seed), 12'h000);
            exec(`ICX_OP_ST_MEM, i, 8'h00, 12'h000);
        end
        for (i = 0; i < 300; i = i + 1) begin
            op = 5'h1F;
            while (op > 5'h15 || op inside {`ICX_OP_PWR_DOWN, `ICX_OP_SUB_EXIT, `ICX_OP_EXIT_IMM, `ICX_OP_IRQ_EXIT})
                op = $random(seed);
            exec(op, $random(seed) & 7, $random(seed), $random(seed));
        end
        for (i = 0; i < 8; i = i + 1)
            exec(`ICX_OP_LD_MEM, i, 8'h00, 12'h000);
        exec(`ICX_OP_CALL, 8'h00, 8'h00, 12'h123);
        exec(`ICX_OP_CALL, 8'h00, 8'h00, 12'h456);
        exec(`ICX_OP_SUB_EXIT, 8'h00, 8'h00, 12'h000);
        exec(`ICX_OP_CALL, 8'h00, 8'h00, 12'h789);
        exec(`ICX_OP_EXIT_IMM, 8'h00, 8'hC3, 12'h000);
        axi_wr(`ICX_OFS_STATUS, 32'h00000000, rs);
        m_c = 1'b0;
        m_z = 1'b0;
        exec(`ICX_OP_IRQ_EXIT, 8'h00, 8'h00, 12'h000);
        repeat (300) @(posedge clk);
        exec(`ICX_OP_PWR_DOWN, 8'h00, 8'h00, 12'h000);
        chk_val(run, 1'b0);
        axi_rd(`ICX_OFS_STATUS, d, rs);
        chk_val(d[5:0], {1'b1, m_g, 2'b01, m_z, m_c});
        axi_rd(`ICX_OFS_WDOG, d, rs);
        chk_val(d, 32'h00000000);
        @(posedge clk);
        wake <= 1'b1;
        @(posedge clk);
        wake <= 1'b0;
        exec(`ICX_OP_IDLE, 8'h00, 8'h00, 12'h000);
        finish_test;
    end
endmodule // icx_core_test
